/* File: logic/pexc_pkg.sv */
// Package holding the constants and carrier types of the exception unit.
package pexc_pkg;
  // Fixed handler vectors.
  localparam logic [31:0] VEC_RESET   = 32'hbfc00000;
  localparam logic [31:0] VEC_USER_TLB_MISS    = 32'h80000000;
  localparam logic [31:0] VEC_GENERAL = 32'h80000080;
  // Register numbers on the control-register move port.
  localparam logic [4:0] REG_CONTEXT  = 5'h04;
  localparam logic [4:0] REG_FAULTING_VADDR = 5'h08;
  localparam logic [4:0] REG_STATUS   = 5'h0c;
  localparam logic [4:0] REG_CAUSE    = 5'h0d;
  localparam logic [4:0] REG_RESTART  = 5'h0e;
  localparam logic [4:0] REG_REVISION = 5'h0f;
  // Status field positions.
  localparam int ST_BOOT_VEC = 22;
  localparam int ST_TLB_OFF  = 21;
  localparam int ST_STACK_HI = 5;
  // Writable status bits; the TLB shutdown flag and reserved bits are 0.
  localparam logic [31:0] ST_WR_MASK = 32'hf05fff3f;
  // Status after reset: boot vectors selected, kernel mode, irqs off.
  localparam logic [31:0] ST_RESET = 32'h00400000;
  // Cause field positions.
  localparam int CA_DELAY   = 31;
  localparam int CA_CE_LO   = 28;
  localparam int CA_HW_LO   = 10;
  localparam int CA_SOFT_LO = 8;
  localparam int CA_CODE_LO = 2;
  // Context field positions.
  localparam int CX_BASE_LO = 21;
  localparam int CX_VPN_LO  = 2;
  // Flush counts by stage of origin.
  localparam logic [2:0] FLUSH_FETCH  = 3'h3;
  localparam logic [2:0] FLUSH_DECODE = 3'h2;
  localparam logic [2:0] FLUSH_ALU    = 3'h3;
  localparam logic [2:0] FLUSH_MEM    = 3'h4;
  localparam logic [2:0] FLUSH_WB     = 3'h5;

  // Five pipeline stages in order.
  typedef enum logic [2:0] {
    STG_FETCH  = 3'b000,
    STG_DECODE = 3'b001,
    STG_ALU    = 3'b010,
    STG_MEM    = 3'b011,
    STG_WB     = 3'b100
  } pexc_stage_t;

  // Exception report from the pipeline.
  typedef struct packed {
    logic        valid;     // Exception detected this cycle.
    pexc_stage_t stage;     // Stage in which it arose.
    logic [3:0]  code;      // Cause code.
    logic        user_tlb_miss;      // User-space TLB miss.
    logic        addrErr;   // Addressing exception, vaddr is valid.
    logic [1:0]  ce;        // Coprocessor number, for unusable faults.
    logic        inDelay;   // Faulting instruction sits in a delay slot.
    logic [31:0] pc;        // Address of the faulting instruction.
    logic [31:0] branchPc;  // Address of the preceding branch.
    logic [31:0] vaddr;     // Offending virtual address.
  } pexc_req_t;

  // Control-register move request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  sel;
    logic [31:0] wdata;
  } pexc_cpreg_t;

  // Whole state of the unit.
  typedef struct packed {
    logic [31:0] status;
    logic        causeDelay;
    logic [1:0]  causeCe;
    logic [3:0]  causeCode;
    logic [1:0]  softIrq;
    logic [5:0]  hwPend;
    logic [31:0] restart;
    logic [31:0] faulting_vaddr;
    logic [10:0] ctxBase;
    logic        bootPending;
    logic        redirValid;
    logic [31:0] redirPc;
    logic [2:0]  flushCount;
    logic [4:0]  killMask;
    logic        irqRequest;
    logic [31:0] rdData;
    logic        rdValid;
  } pexc_state_t;
endpackage : pexc_pkg

/* File: logic/pexc_unit.sv */
// Exception control unit: restart capture, cause, status and redirect.
`timescale 1ns/1ns

// Contract
// - Abort faulting and younger instructions, jump handler (fetch faults here abort three stages: fetch, decode, ALU).
// - Restart address takes faulting instruction address.
// - Delay slot: restart takes preceding branch address.
// - Cause holds last exception, 4-bit code.
// - Cause read-only except writable soft irq bits.
// - Status all writable except TLB shutdown flag (reserved bits 7:6 and 27:23 are also read-only here).
// - Any exception enters kernel mode.
// - Reset fetches from the boot vector.
// - User TLB miss fetches from its vector.
// - Other exceptions fetch from general vector.
// - Handler fetch starts one cycle after detection.
// - Five stages: fetch, decode, ALU, memory, write-back.
// - Flush count depends on stage of origin.
// - Addressing exceptions capture whole bad address.
// - Context shows bad address for refill handlers.
// - Revision register reports implementation and revision.
// - Mode/enable stack shifts; current pair cleared.
// - Cause shows pending hardware and software irqs.
module pexc_unit #(
  parameter logic [31:0] REVISION_ID = 32'h00000a01  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // Exception reports and interrupt lines.
  input  wire pexc_pkg::pexc_req_t  excReq,
  input  wire logic [5:0]           hwIrq,
  input  wire logic                 tlbShutdown,
  // Control-register move port.
  input  wire pexc_pkg::pexc_cpreg_t cpReg,
  output logic [31:0]               rdData,
  output logic                      rdValid,
  // Pipeline control.
  output logic                      redirValid,
  output logic [31:0]               redirPc,
  output logic [2:0]                flushCount,
  output logic [4:0]                killMask,
  output logic                      irqRequest,
  output logic                      kernelMode
);

  // Reset asserts at once but releases two edges late, so that every
  // flop of the unit leaves reset on the same clock edge.
  logic [1:0]            rstPipe;  // Reset release synchroniser.
  logic                  rstN;     // Synchronised reset, active low.
  pexc_pkg::pexc_state_t st;       // Registered state.
  pexc_pkg::pexc_state_t next_st;  // Next state.

  // Flush count per stage of origin.
  function automatic logic [2:0] flushFor(input pexc_pkg::pexc_stage_t s);
    case (s)
      pexc_pkg::STG_FETCH:  flushFor = pexc_pkg::FLUSH_FETCH;
      pexc_pkg::STG_DECODE: flushFor = pexc_pkg::FLUSH_DECODE;
      pexc_pkg::STG_ALU:    flushFor = pexc_pkg::FLUSH_ALU;
      pexc_pkg::STG_MEM:    flushFor = pexc_pkg::FLUSH_MEM;
      default:              flushFor = pexc_pkg::FLUSH_WB;
    endcase
  endfunction : flushFor

  // Kill mask: the lowest flushCount stages, youngest first.
  // Bit 0 is fetch and bit 4 write-back, so the mask grows from the
  // youngest end; the shift is one bit wider so that five cannot wrap.
  function automatic logic [4:0] maskFor(input logic [2:0] n);
    maskFor = 5'((6'h01 << n) - 6'h01);
  endfunction : maskFor

  // Assemble the cause register from its fields.
  function automatic logic [31:0] causeWord(input pexc_pkg::pexc_state_t s);
    causeWord = 32'h00000000;
    causeWord[pexc_pkg::CA_DELAY] = s.causeDelay;
    causeWord[pexc_pkg::CA_CE_LO +: 2] = s.causeCe;
    causeWord[pexc_pkg::CA_HW_LO +: 6] = s.hwPend;
    causeWord[pexc_pkg::CA_SOFT_LO +: 2] = s.softIrq;
    causeWord[pexc_pkg::CA_CODE_LO +: 4] = s.causeCode;
  endfunction : causeWord

  // Reset is released through two flops; the second alone is used.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  // Next-state logic for the whole unit.
  always_comb begin
    logic [31:0] stw;
    logic [31:0] ctx;
    stw = 32'h00000000;
    ctx = 32'h00000000;
    next_st = st;
    next_st.redirValid = 1'b0;
    next_st.rdValid = 1'b0;
    // Pending lines are level-sensitive and never latched.
    next_st.hwPend = hwIrq;
    // The shutdown flag is hardware-owned and sticks until reset.
    if (tlbShutdown) begin
      next_st.status[pexc_pkg::ST_TLB_OFF] = 1'b1;
    end
    // Software writes; the read-only bits are protected by masks.
    if (cpReg.wr) begin
      if (cpReg.sel == pexc_pkg::REG_STATUS) begin
        // Only bits in ST_WR_MASK take the write; the shutdown flag and reserved bits hold.
        next_st.status = (cpReg.wdata & pexc_pkg::ST_WR_MASK)
                       | (next_st.status & ~pexc_pkg::ST_WR_MASK);
      end else if (cpReg.sel == pexc_pkg::REG_CAUSE) begin
        // Only the software irq bits of the cause register move.
        next_st.softIrq = cpReg.wdata[pexc_pkg::CA_SOFT_LO +: 2];
      end else if (cpReg.sel == pexc_pkg::REG_CONTEXT) begin
        // The table base is software's; the page part is hardware's.
        next_st.ctxBase = cpReg.wdata[pexc_pkg::CX_BASE_LO +: 11];
      end else begin
        // Other numbers are read-only or unmapped; the write is lost.
        next_st.rdValid = 1'b0;
      end
    end
    // An exception overrides bits 5:0 of a same-cycle software status write; the other bits still land.
    if (st.bootPending) begin
      // First action after reset: fetch from the boot vector.
      next_st.bootPending = 1'b0;
      next_st.redirValid = 1'b1;
      next_st.redirPc = pexc_pkg::VEC_RESET;
      next_st.flushCount = pexc_pkg::FLUSH_WB;
      next_st.killMask = maskFor(pexc_pkg::FLUSH_WB);
    end else if (excReq.valid) begin
      // Abort the faulter and all younger work one cycle later; a fetch fault also kills decode and ALU.
      next_st.redirValid = 1'b1;
      next_st.flushCount = flushFor(excReq.stage);
      next_st.killMask = maskFor(flushFor(excReq.stage));
      // Vector choice: user TLB miss or the general vector.
      if (excReq.user_tlb_miss) begin
        next_st.redirPc = pexc_pkg::VEC_USER_TLB_MISS;
      end else begin
        next_st.redirPc = pexc_pkg::VEC_GENERAL;
      end
      // Restart address, corrected for the delay slot.
      if (excReq.inDelay) begin
        next_st.restart = excReq.branchPc;
      end else begin
        next_st.restart = excReq.pc;
      end
      next_st.causeDelay = excReq.inDelay;
      next_st.causeCode = excReq.code;
      next_st.causeCe = excReq.ce;
      // Addressing faults keep the whole address.
      if (excReq.addrErr) begin
        next_st.faulting_vaddr = excReq.vaddr;
      end
      // Shift the mode/enable stack and clear the current pair.
      stw = next_st.status;
      stw[pexc_pkg::ST_STACK_HI -: 4] = st.status[3:0];
      stw[1:0] = 2'b00;
      next_st.status = stw;
    end
    // Interrupt request toward the pipeline: pending, masked, enabled.
    // A fault in the same cycle wins and the request drops for it; the
    // fault also clears status bit 0, so the levels ask again only once it is set again.
    next_st.irqRequest = st.status[0]
      & (|({st.hwPend, st.softIrq} & st.status[15:8])) & ~excReq.valid;
    // Register reads answer on the next edge.
    // Reads see the state before this edge's update, so a read in the
    // same cycle as an exception returns the older contents.
    if (cpReg.rd) begin
      next_st.rdValid = 1'b1;
      ctx[pexc_pkg::CX_BASE_LO +: 11] = st.ctxBase;
      ctx[pexc_pkg::CX_VPN_LO +: 19] = st.faulting_vaddr[30:12];
      if (cpReg.sel == pexc_pkg::REG_STATUS) begin
        next_st.rdData = st.status;
      end else if (cpReg.sel == pexc_pkg::REG_CAUSE) begin
        next_st.rdData = causeWord(st);
      end else if (cpReg.sel == pexc_pkg::REG_RESTART) begin
        next_st.rdData = st.restart;
      end else if (cpReg.sel == pexc_pkg::REG_FAULTING_VADDR) begin
        next_st.rdData = st.faulting_vaddr;
      end else if (cpReg.sel == pexc_pkg::REG_CONTEXT) begin
        next_st.rdData = ctx;
      end else if (cpReg.sel == pexc_pkg::REG_REVISION) begin
        next_st.rdData = REVISION_ID;
      end else begin
        next_st.rdData = 32'h00000000;  // Unmapped numbers read zero.
      end
    end
  end

  // State register; reset leaves a boot redirect pending.
  // Keeping it as a state bit keeps every output a plain flop, at the
  // cost of ignoring an exception reported in that single cycle.
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      st <= '0;
      st.status <= pexc_pkg::ST_RESET;
      st.bootPending <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flops.
  assign rdData = st.rdData;
  assign rdValid = st.rdValid;
  assign redirValid = st.redirValid;
  assign redirPc = st.redirPc;
  assign flushCount = st.flushCount;
  assign killMask = st.killMask;
  assign irqRequest = st.irqRequest;
  assign kernelMode = ~st.status[1];

  // Checks on the unit's own state and outputs.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  // A taken exception redirects on the very next edge.
  redirect_next_a: assert property (
    excReq.valid && !st.bootPending |=> redirValid)
    else $error("Exception did not redirect one cycle later.");
  user_tlb_miss_vector_a: assert property (
    excReq.valid && excReq.user_tlb_miss && !st.bootPending
      |=> redirPc == 32'h80000000)
    else $error("User TLB miss took the wrong vector.");
  general_vector_a: assert property (
    excReq.valid && !excReq.user_tlb_miss && !st.bootPending
      |=> redirPc == 32'h80000080)
    else $error("General exception took the wrong vector.");
  boot_vector_a: assert property (
    $rose(rstN) |-> ##1 redirValid && redirPc == 32'hbfc00000)
    else $error("No boot redirect after reset.");
  restart_addr_a: assert property (
    excReq.valid && !st.bootPending |=> st.restart ==
      ($past(excReq.inDelay) ? $past(excReq.branchPc) : $past(excReq.pc)))
    else $error("Restart address wrong.");
  mode_stack_a: assert property (
    excReq.valid && !st.bootPending |=> kernelMode && !st.status[0]
      && st.status[5:2] == $past(st.status[3:0]))
    else $error("Mode stack not shifted.");
  flush_count_a: assert property (
    excReq.valid && excReq.stage == pexc_pkg::STG_MEM && !st.bootPending
      |=> flushCount == 3'h4 && killMask == 5'h0f)
    else $error("Memory-stage flush count wrong.");
  delay_flag_a: assert property (
    excReq.valid && !st.bootPending
      |=> st.causeDelay == $past(excReq.inDelay))
    else $error("Delay flag wrong.");
  tlb_flag_a: assert property (
    !tlbShutdown && cpReg.wr && cpReg.sel == pexc_pkg::REG_STATUS
      |=> $stable(st.status[21]))
    else $error("Software changed the shutdown flag.");
  cause_ro_a: assert property (
    !excReq.valid && cpReg.wr && cpReg.sel == pexc_pkg::REG_CAUSE
      |=> $stable(st.causeCode) && $stable(st.causeDelay))
    else $error("Cause read-only field changed.");

  // Fetch-stage faults flush three stages.
  flush_fetch_a: assert property (
    excReq.valid && excReq.stage == pexc_pkg::STG_FETCH && !st.bootPending
      |=> flushCount == 3'h3 && killMask == 5'h07)
    else $error("Fetch-stage flush count wrong.");
  // Decode-stage faults flush two stages.
  flush_decode_a: assert property (
    excReq.valid && excReq.stage == pexc_pkg::STG_DECODE && !st.bootPending
      |=> flushCount == 3'h2 && killMask == 5'h03)
    else $error("Decode-stage flush count wrong.");
  // ALU-stage faults flush three stages.
  flush_alu_a: assert property (
    excReq.valid && excReq.stage == pexc_pkg::STG_ALU && !st.bootPending
      |=> flushCount == 3'h3 && killMask == 5'h07)
    else $error("ALU-stage flush count wrong.");
  // Write-back faults abort all five stages.
  flush_wb_a: assert property (
    excReq.valid && excReq.stage == pexc_pkg::STG_WB && !st.bootPending
      |=> flushCount == 3'h5 && killMask == 5'h1f)
    else $error("Write-back flush count wrong.");
  // The boot redirect clears the whole pipeline.
  boot_kill_a: assert property (
    $rose(rstN) |-> ##1 flushCount == 3'h5 && killMask == 5'h1f)
    else $error("Boot redirect did not flush everything.");

  // Without a new exception the redirect is a single-cycle pulse.
  redirect_pulse_a: assert property (
    !excReq.valid && !st.bootPending |=> !redirValid)
    else $error("Redirect stood longer than one cycle.");
  // The cause code and coprocessor field describe the latest fault.
  cause_code_a: assert property (
    excReq.valid && !st.bootPending
      |=> st.causeCode == $past(excReq.code)
        && st.causeCe == $past(excReq.ce))
    else $error("Cause code not captured.");
  // Addressing faults keep the whole offending address.
  bad_addr_a: assert property (
    excReq.valid && excReq.addrErr && !st.bootPending
      |=> st.faulting_vaddr == $past(excReq.vaddr))
    else $error("Bad address not captured.");

  // A software cause write moves the soft irq bits.
  soft_write_a: assert property (
    cpReg.wr && cpReg.sel == pexc_pkg::REG_CAUSE
      |=> st.softIrq == $past(cpReg.wdata[9:8]))
    else $error("Soft irq bits not written.");
  // A plain status write lands through the write mask.
  status_write_a: assert property (
    cpReg.wr && cpReg.sel == pexc_pkg::REG_STATUS && !excReq.valid
      && !tlbShutdown
      |=> st.status == (($past(cpReg.wdata) & 32'hf05fff3f)
        | ($past(st.status) & ~32'hf05fff3f)))
    else $error("Status write did not land.");
  // The shutdown flag, once raised by hardware, reads back set.
  tlb_set_a: assert property (
    tlbShutdown |=> st.status[21])
    else $error("Shutdown flag not set.");
  // Hardware pending bits follow the lines one cycle late.
  pend_follow_a: assert property (
    !st.bootPending |=> st.hwPend == $past(hwIrq))
    else $error("Pending lines not tracked.");
  // With interrupts disabled no request reaches the pipeline.
  irq_gate_a: assert property (
    !st.status[0] |=> !irqRequest)
    else $error("Interrupt request while disabled.");
  // A revision read answers one cycle later with the fixed value.
  revision_read_a: assert property (
    cpReg.rd && cpReg.sel == pexc_pkg::REG_REVISION
      |=> rdValid && rdData == REVISION_ID)
    else $error("Revision read wrong.");

  // Main scenarios.
  user_tlb_miss_seen_c: cover property (excReq.valid && excReq.user_tlb_miss);
  delay_seen_c: cover property (excReq.valid && excReq.inDelay);
  soft_irq_c: cover property (irqRequest && st.softIrq != 2'h0);
  back2back_c: cover property (excReq.valid ##1 excReq.valid);
  mem_flush_c: cover property (
    excReq.valid && excReq.stage == pexc_pkg::STG_MEM);
endmodule : pexc_unit

/* File: tb/pexc_unit_test.sv */
// Self-checking bench for the exception control unit.
`timescale 1ns/1ns
module pexc_unit_test;
  // Arbitrary revision value handed to the design.
  localparam logic [31:0] REV_ID = 32'h00005a17;
  // Clock, reset and stimulus.
  logic                  ref_clk;
  logic                  resetn;
  pexc_pkg::pexc_req_t   excReq;
  logic [5:0]            hwIrq;
  logic                  tlbShutdown;
  pexc_pkg::pexc_cpreg_t cpReg;
  // Design outputs.
  logic [31:0]           rdData;
  logic                  rdValid;
  logic                  redirValid;
  logic [31:0]           redirPc;
  logic [2:0]            flushCount;
  logic [4:0]            killMask;
  logic                  irqRequest;
  logic                  kernelMode;
  // Counters and reference model state.
  int                    error_cnt = 0;
  int                    checks_done = 0;
  int                    cycles = 0;
  integer                seed = 27;
  logic [31:0]           mStatus, mRestart, mBad, rdSeen, ctxWr;
  logic [10:0]           mBase;
  logic [3:0]            mCode;
  logic [1:0]            mCe, mSoft;
  logic                  mDelay, rdvSeen;
  pexc_pkg::pexc_req_t   r, r2;
  int                    flushTab [5] = '{3, 2, 3, 4, 5};

  pexc_unit #(.REVISION_ID(REV_ID)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .excReq(excReq), .hwIrq(hwIrq),
    .tlbShutdown(tlbShutdown), .cpReg(cpReg), .rdData(rdData),
    .rdValid(rdValid), .redirValid(redirValid), .redirPc(redirPc),
    .flushCount(flushCount), .killMask(killMask),
    .irqRequest(irqRequest), .kernelMode(kernelMode));

  // Free-running 50 ns clock.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Hang guard; the whole run needs a few hundred cycles.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Compares one value, widened to a word, and counts it.
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Expected cause word from the model; pending lines are live levels.
  function automatic logic [31:0] causeExp();
    return {mDelay, 1'b0, mCe, 12'h0, hwIrq, mSoft, 2'b0, mCode, 2'b0};
  endfunction : causeExp

  // One register move; an idle cycle follows so strobes never merge.
  task automatic cp(input logic wr, input logic [4:0] sel,
                    input logic [31:0] wd);
    cpReg = '{~wr, wr, sel, wd};
    @(negedge ref_clk);
    rdSeen = rdData;
    rdvSeen = rdValid;
    cpReg = '0;
    @(negedge ref_clk);
  endtask : cp

  // Reads a register and checks the answer cycle.
  task automatic rdChk(input logic [4:0] sel, input logic [31:0] exp,
                       input string nm);
    cp(1'b0, sel, 32'h0);
    chk({nm, " valid"}, 32'h1, {31'h0, rdvSeen});
    chk(nm, exp, rdSeen);
  endtask : rdChk

  // Status write in the model: the shutdown flag is hardware owned.
  task automatic wrStatus(input logic [31:0] w);
    cp(1'b1, pexc_pkg::REG_STATUS, w);
    mStatus = (w & pexc_pkg::ST_WR_MASK) | {10'h0, tlbShutdown, 21'h0};
  endtask : wrStatus

  // Presents request a for one cycle, then request b (maybe idle).
  task automatic takeExc(input pexc_pkg::pexc_req_t a,
                         input pexc_pkg::pexc_req_t b);
    int n;
    if (excReq !== a) begin
      excReq = a;
    end
    @(negedge ref_clk);
    excReq = b;
    n = flushTab[a.stage];
    mStatus[5:0] = {mStatus[3:0], 2'b00};
    mRestart = a.inDelay ? a.branchPc : a.pc;
    if (a.addrErr) begin
      mBad = a.vaddr;
    end
    {mDelay, mCe, mCode} = {a.inDelay, a.ce, a.code};
    chk("redirect", 32'h1, {31'h0, redirValid});
    chk("vector", a.user_tlb_miss ? pexc_pkg::VEC_USER_TLB_MISS
                         : pexc_pkg::VEC_GENERAL, redirPc);
    chk("flush", 32'(n), {29'h0, flushCount});
    chk("kill", 32'((1 << n) - 1), {27'h0, killMask});
    chk("kernel", 32'h1, {31'h0, kernelMode});
  endtask : takeExc

  // Main sequence.
  initial begin
    resetn = 1'b0;
    excReq = '0;
    cpReg = '0;
    tlbShutdown = 1'b0;
    hwIrq = 6'($random(seed));
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("boot redirect", 32'h1, {31'h0, redirValid});
    chk("boot vector", pexc_pkg::VEC_RESET, redirPc);
    chk("boot kill", 32'h1f, {27'h0, killMask});
    mStatus = pexc_pkg::ST_RESET;
    {mDelay, mCe, mCode, mSoft, mRestart, mBad, mBase} = '0;
    rdChk(pexc_pkg::REG_STATUS, mStatus, "status reset");
    rdChk(pexc_pkg::REG_REVISION, REV_ID, "revision");
    rdChk(5'h1f, 32'h0, "unmapped");
    $display("test reset done");
    // Status access and the read-only shutdown flag.
    wrStatus(32'hffffffff);
    rdChk(pexc_pkg::REG_STATUS, mStatus, "status ones");
    chk("user mode", 32'h0, {31'h0, kernelMode});
    tlbShutdown = 1'b1;
    wrStatus(32'h00000000);
    rdChk(pexc_pkg::REG_STATUS, mStatus, "status ts");
    // Pending lines and the software bits of the cause word.
    cp(1'b1, pexc_pkg::REG_CAUSE, 32'hffffffff);
    mSoft = 2'b11;
    rdChk(pexc_pkg::REG_CAUSE, causeExp(), "cause soft");
    wrStatus(32'h0000ff01);
    chk("irq req", 32'h1, {31'h0, irqRequest});
    cp(1'b1, pexc_pkg::REG_CAUSE, 32'h00000100);
    mSoft = 2'b01;
    rdChk(pexc_pkg::REG_CAUSE, causeExp(), "cause clr");
    ctxWr = 32'($random(seed));
    cp(1'b1, pexc_pkg::REG_CONTEXT, ctxWr);
    mBase = ctxWr[31:21];
    $display("test registers done");
    // Exceptions from every stage, with delay slots and three back-to-back pairs.
    for (int i = 0; i < 15; i++) begin
      wrStatus(32'($random(seed)));
      r = '0;
      r.valid = 1'b1;
      r.stage = pexc_pkg::pexc_stage_t'(i % 5);
      r.code = 4'($random(seed));
      r.user_tlb_miss = 1'($random(seed));
      r.addrErr = 1'($random(seed));
      r.ce = 2'($random(seed));
      r.inDelay = 1'($random(seed));
      r.pc = 32'($random(seed));
      r.branchPc = r.pc - 32'h4;
      r.vaddr = 32'($random(seed));
      r2 = r;
      r2.stage = pexc_pkg::pexc_stage_t'((i + 2) % 5);
      r2.pc = 32'($random(seed));
      r2.inDelay = ~r.inDelay;
      if (i > 11) begin
        takeExc(r, r2);
        takeExc(r2, '0);
      end else begin
        takeExc(r, '0);
      end
      @(negedge ref_clk);
      chk("redirect drop", 32'h0, {31'h0, redirValid});
      rdChk(pexc_pkg::REG_STATUS, mStatus, "stack");
      rdChk(pexc_pkg::REG_CAUSE, causeExp(), "cause");
      rdChk(pexc_pkg::REG_RESTART, mRestart, "restart");
      rdChk(pexc_pkg::REG_FAULTING_VADDR, mBad, "bad addr");
      rdChk(pexc_pkg::REG_CONTEXT, {mBase, mBad[30:12], 2'b00},
            "context");
    end
    cp(1'b1, pexc_pkg::REG_RESTART, 32'h0);
    rdChk(pexc_pkg::REG_RESTART, mRestart, "restart ro");
    $display("test exceptions done");
    report_and_stop();
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
endmodule : pexc_unit_test
